// ===== design/acqc_pkg.sv
/*
  acqc_pkg: constants, carrier structs and state codes of the
  acquisition chain control block.
  Assumes a 10 MHz reference clock and an APB master with 32-bit data.
*/
package acqc_pkg;
  // ==========================================================
  // timing
  localparam int unsigned REF_CLK_KHZ = 10000; // reference clock rate
  localparam int unsigned SLOW_CLK_KHZ = 512; // die link slow clock
  localparam int unsigned AZ_SLOW_CYCLES = 3352; // calibration length
  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] IDX_VSENSE = 8'h4B;
  localparam logic [7:0] IDX_TSENSE = 8'h4C;
  localparam logic [7:0] IDX_ACQUISITION_CONTROL = 8'h58;
  localparam logic [7:0] IDX_ACQ_STAT = 8'h5A;
  localparam logic [7:0] IDX_CHAIN_MAIN = 8'h5C;
  localparam logic [7:0] IDX_CHAIN_ZERO = 8'h5E;
  localparam logic [7:0] IDX_DEC = 8'h60;
  localparam logic [7:0] IDX_REFCTL = 8'h61;
  localparam logic [7:0] IDX_GAIN = 8'h62;
  localparam logic [7:0] IDX_GCB = 8'h63;
  localparam logic [7:0] IDX_ITEMP = 8'h64;
  localparam logic [7:0] IDX_ETEMP = 8'h66;
  localparam logic [7:0] IDX_CURR_UP = 8'h68;
  localparam logic [7:0] IDX_CURR_LO = 8'h6A;
  localparam logic [7:0] IDX_VOLT = 8'h6C;
  localparam logic [7:0] IDX_FILTER_COEFFICIENT_INDEX = 8'h6E;
  localparam logic [7:0] IDX_COMPENSATION_CONTROL_REGISTER = 8'hA0;
  localparam logic [7:0] IDX_AZ_STAT = 8'hA2;
  localparam logic [5:0] IDX_AZ_CORR_GRP = 6'h29; // 0xA4..0xA7
  localparam logic [7:0] IDX_IRQ_STAT = 8'hA8;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hA9;
  // ==========================================================
  // field positions and masks
  localparam int unsigned AZ_RUN_POS = 0; // run bit in compensation ctl
  localparam int unsigned AZ_MASK_POS = 8; // its write mask
  localparam int unsigned AZ_DONE_POS = 0; // done flag in az status
  localparam int unsigned IRQ_AZ_POS = 0; // calibration finished
  localparam int unsigned IRQ_MEAS_POS = 1; // any measurement event
  localparam logic [7:0] ACQUISITION_CONTROL_WMASK = 8'hBF; // bit 6 unused
  localparam logic [7:0] CHAIN_ZERO_WMASK = 8'h80;
  localparam logic [7:0] GAIN_WMASK = 8'hFE; // bit 0 unused
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic [7:0] vsense; // [4:0] input enables, [7:5] input select
    logic [4:0] tsense; // temperature input enables
    logic [7:0] acquisition_control; // acquisition control bits
    logic [7:0] chain_main; // chain options
    logic [7:0] chain_zero; // zero option in bit 7
    logic [2:0] dec; // decimation rate
    logic [7:0] gain; // amplifier gain setting
    logic [7:0] gcb; // gain switch threshold
    logic [3:0] filter_coefficient_index; // filter coefficient index
  } acqc_cfg_t;
  typedef struct packed {
    logic [15:0] itemp;
    logic [15:0] etemp;
    logic [23:0] curr;
    logic [15:0] volt;
  } acqc_res_t;
  typedef enum logic [1:0] {
    AZ_IDLE = 2'b00,
    AZ_RUN = 2'b01,
    AZ_DONE = 2'b11
  } acqc_az_state_t;
endpackage : acqc_pkg

// ===== design/acqc_top.sv
/*
  acqc_top: register file, amplifier zero calibration sequencer and
  interrupt logic of the acquisition chain, reached over APB.
  Assumes one 10 MHz clock, APB master in the same domain, and that
  measurement events and results arrive synchronous to ref_clk.
*/
// Design decision made here: the APB slave port.
// Operation
// - done flag appears after calibration; polled
// - done flag clears by writing one
// - calibration lasts 3352 slow clock cycles
// - finish stores eleven-bit offset per gain
// - filter index low four bits, upper zero
// - voltage pins: five enables plus select
// - temperature pins: five enables, upper zero
`timescale 1ns/1ps
module acqc_top import acqc_pkg::*; #(
  parameter int unsigned AZ_TICKS = AZ_SLOW_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // measurement chain
  input wire logic [7:0] meas_evt,
  input wire logic [4:0] chain_status,
  input wire acqc_res_t results,
  input wire logic [3:0][10:0] az_offset_meas,
  // control outputs
  output acqc_cfg_t cfg,
  output logic autozero_run_bit,
  output logic irq
);
  // ==========================================================
  // bus decode
  logic [31:0] prdata_r; // latched read word
  logic pready_r; // access phase answer
  logic pslverr_r; // unmapped address
  logic [31:0] rd_word; // selected read word
  logic rd_hit; // address is mapped
  wire [7:0] idx = paddr[9:2]; // register index
  wire setup_ph = psel & ~penable;
  wire wr_en = psel & penable & pready_r & pwrite & ~pslverr_r;
  wire [7:0] wr_lo = pwdata[7:0];
  wire [7:0] wr_hi = pwdata[15:8];
  wire idx_hi_ok = (paddr[11:10] == 2'b00);
  // ==========================================================
  // state
  acqc_cfg_t cfg_r; // configuration registers
  logic [7:0] acq_flags_r; // sticky measurement flags
  logic run_r; // calibration run bit
  logic done_r; // calibration done flag
  acqc_az_state_t state_r, state_nxt;
  logic [13:0] acc_r; // fractional slow tick generator
  logic [11:0] tick_cnt_r; // slow ticks since start
  logic [3:0][10:0] az_corr_r; // stored offset corrections
  logic [1:0] irq_stat_r, irq_mask_r;
  logic irq_r;

  // paired byte update: mask bit one lets the value bit through
  function automatic logic [7:0] masked_upd(input logic [7:0] old_v,
      input logic [7:0] val, input logic [7:0] msk);
    masked_upd = (old_v & ~msk) | (val & msk);
  endfunction : masked_upd

  // one-hot write strobe per index
  function automatic logic wr_to(input logic [7:0] i);
    wr_to = wr_en && (idx == i);
  endfunction : wr_to

  // ==========================================================
  // read mux
  always_comb begin
    rd_word = RST_WORD;
    rd_hit = idx_hi_ok;
    unique case (idx)
      IDX_VSENSE: rd_word[7:0] = cfg_r.vsense;
      IDX_TSENSE: rd_word[4:0] = cfg_r.tsense; // upper read zero
      IDX_ACQUISITION_CONTROL: rd_word[7:0] = cfg_r.acquisition_control; // masks read zero
      IDX_ACQ_STAT: rd_word[15:0] = {acq_flags_r, 3'b000, chain_status};
      IDX_CHAIN_MAIN: rd_word[7:0] = cfg_r.chain_main;
      IDX_CHAIN_ZERO: rd_word[7:0] = cfg_r.chain_zero;
      IDX_DEC: rd_word[2:0] = cfg_r.dec;
      IDX_REFCTL: rd_word = RST_WORD; // reserved, reads zero
      IDX_GAIN: rd_word[7:0] = cfg_r.gain;
      IDX_GCB: rd_word[7:0] = cfg_r.gcb;
      IDX_ITEMP: rd_word[15:0] = results.itemp;
      IDX_ETEMP: rd_word[15:0] = results.etemp;
      IDX_CURR_UP: rd_word[7:0] = results.curr[23:16];
      IDX_CURR_LO: rd_word[15:0] = results.curr[15:0];
      IDX_VOLT: rd_word[15:0] = results.volt;
      IDX_FILTER_COEFFICIENT_INDEX: rd_word[3:0] = cfg_r.filter_coefficient_index;
      IDX_COMPENSATION_CONTROL_REGISTER: rd_word[AZ_RUN_POS] = run_r;
      IDX_AZ_STAT: rd_word[AZ_DONE_POS] = done_r; // polled flag
      IDX_IRQ_STAT: rd_word[1:0] = irq_stat_r;
      IDX_IRQ_MASK: rd_word[1:0] = irq_mask_r;
      default: begin
        // offset corrections sit in a block of four words
        if (idx[7:2] == IDX_AZ_CORR_GRP) begin
          rd_word[10:0] = az_corr_r[idx[1:0]];
        end else begin
          rd_hit = 1'b0;
        end
      end
    endcase
  end

  // ==========================================================
  // apb answer: data latched in setup, one access cycle, no waits
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      prdata_r <= RST_WORD;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= setup_ph;
      if (setup_ph) begin
        prdata_r <= rd_word;
        pslverr_r <= ~rd_hit;
      end
    end
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_r <= '0;
    end else begin
      if (wr_to(IDX_VSENSE)) cfg_r.vsense <= wr_lo;
      if (wr_to(IDX_TSENSE)) cfg_r.tsense <= wr_lo[4:0];
      if (wr_to(IDX_ACQUISITION_CONTROL)) begin
        cfg_r.acquisition_control <= masked_upd(cfg_r.acquisition_control, wr_lo,
          wr_hi & ACQUISITION_CONTROL_WMASK);
      end
      if (wr_to(IDX_CHAIN_MAIN)) begin
        cfg_r.chain_main <= masked_upd(cfg_r.chain_main, wr_lo, wr_hi);
      end
      if (wr_to(IDX_CHAIN_ZERO)) begin
        cfg_r.chain_zero <= masked_upd(cfg_r.chain_zero, wr_lo,
          wr_hi & CHAIN_ZERO_WMASK);
      end
      if (wr_to(IDX_DEC)) cfg_r.dec <= wr_lo[2:0];
      if (wr_to(IDX_GAIN)) cfg_r.gain <= wr_lo & GAIN_WMASK;
      if (wr_to(IDX_GCB)) cfg_r.gcb <= wr_lo;
      if (wr_to(IDX_FILTER_COEFFICIENT_INDEX)) cfg_r.filter_coefficient_index <= wr_lo[3:0];
    end
  end

  // ==========================================================
  // measurement flags: a new event wins over a clear
  wire [7:0] acq_clr = wr_to(IDX_ACQ_STAT) ? wr_hi : RST_BYTE;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      acq_flags_r <= RST_BYTE;
    end else begin
      acq_flags_r <= (acq_flags_r & ~acq_clr) | meas_evt;
    end
  end

  // ==========================================================
  // calibration sequencer
  // run bit moves only with its mask in the same write
  wire comp_wr = wr_to(IDX_COMPENSATION_CONTROL_REGISTER) && pwdata[AZ_MASK_POS];
  wire run_nxt = comp_wr ? pwdata[AZ_RUN_POS] : run_r;
  wire az_start = run_nxt & ~run_r;
  // slow clock is emulated by a rate accumulator, so no second domain
  wire [14:0] acc_sum = {1'b0, acc_r} + 15'(SLOW_CLK_KHZ);
  wire slow_tick = (acc_sum >= 15'(REF_CLK_KHZ));
  wire [13:0] acc_nxt = slow_tick ? 14'(acc_sum - 15'(REF_CLK_KHZ))
                                  : acc_sum[13:0];
  wire [11:0] tick_last = 12'(AZ_TICKS - 1);
  // an abort in the finishing cycle wins, so no stray done flag
  wire az_finish = (state_r == AZ_RUN) && run_nxt && slow_tick &&
                   (tick_cnt_r == tick_last);

  // next state; clearing run mid-sequence abandons it
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      AZ_IDLE: if (az_start) state_nxt = AZ_RUN;
      AZ_RUN: begin
        if (!run_nxt) state_nxt = AZ_IDLE;
        else if (az_finish) state_nxt = AZ_DONE;
      end
      AZ_DONE: if (!run_nxt) state_nxt = AZ_IDLE; // exit by software
      default: state_nxt = AZ_IDLE; // fourth code is illegal
    endcase
  end

  // run bit, state and slow tick counting
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      run_r <= 1'b0;
      state_r <= AZ_IDLE;
      acc_r <= '0;
      tick_cnt_r <= '0;
    end else begin
      run_r <= run_nxt;
      state_r <= state_nxt;
      acc_r <= (state_r == AZ_RUN) ? acc_nxt : '0;
      if (state_r != AZ_RUN) tick_cnt_r <= '0;
      else if (slow_tick) tick_cnt_r <= tick_cnt_r + 12'h001;
    end
  end

  // done flag: finish wins over a write-one clear
  wire done_clr = wr_to(IDX_AZ_STAT) && pwdata[AZ_DONE_POS];
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      done_r <= 1'b0;
    end else begin
      done_r <= az_finish | (done_r & ~done_clr);
    end
  end

  // corrections captured once per finished sequence
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      az_corr_r <= '0;
    end else if (az_finish) begin
      az_corr_r <= az_offset_meas;
    end
  end

  // ==========================================================
  // interrupts: sticky, write one to clear, masked onto irq
  wire [1:0] irq_set = {|meas_evt, az_finish};
  wire [1:0] irq_clr = wr_to(IDX_IRQ_STAT) ? pwdata[1:0] : 2'b00;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq_stat_r <= 2'b00;
      irq_mask_r <= 2'b00;
      irq_r <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
      if (wr_to(IDX_IRQ_MASK)) irq_mask_r <= pwdata[1:0];
      irq_r <= |(irq_stat_r & irq_mask_r); // one cycle behind status
    end
  end

  // ==========================================================
  // outputs
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign cfg = cfg_r;
  assign autozero_run_bit = run_r;
  assign irq = irq_r;

  // ==========================================================
  // assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  property p_no_early_done;
    (state_r == AZ_RUN) && !az_finish |=> !$rose(done_r);
  endproperty
  a_no_early_done: assert property (p_no_early_done)
    else $error("done flag rose before the sequence ended");

  property p_done_clear;
    done_clr && !az_finish |=> !done_r;
  endproperty
  a_done_clear: assert property (p_done_clear)
    else $error("write one did not clear done flag");

  property p_done_keep;
    done_r && !done_clr |=> done_r;
  endproperty
  a_done_keep: assert property (p_done_keep)
    else $error("done flag lost without a clear");

  property p_finish_count;
    $rose(done_r) |-> $past(state_r) == AZ_RUN &&
      $past(tick_cnt_r) == tick_last && state_r == AZ_DONE;
  endproperty
  a_finish_count: assert property (p_finish_count)
    else $error("done raised at the wrong tick count");

  property p_corr_store;
    az_finish |=> az_corr_r == $past(az_offset_meas);
  endproperty
  a_corr_store: assert property (p_corr_store)
    else $error("offset corrections not stored at finish");

  property p_filter_coefficient_index_read;
    setup_ph && idx == IDX_FILTER_COEFFICIENT_INDEX |=> pready && prdata[31:4] == 28'h0;
  endproperty
  a_filter_coefficient_index_read: assert property (p_filter_coefficient_index_read)
    else $error("filter index upper bits not zero");

  property p_vsense_wr;
    wr_to(IDX_VSENSE) |=> cfg.vsense == $past(pwdata[7:0]);
  endproperty
  a_vsense_wr: assert property (p_vsense_wr)
    else $error("voltage pin configuration not written");

  property p_tsense_read;
    setup_ph && idx == IDX_TSENSE |=> prdata[31:5] == 27'h0;
  endproperty
  a_tsense_read: assert property (p_tsense_read)
    else $error("temperature pin upper bits not zero");

  property p_chain_mask;
    wr_to(IDX_CHAIN_MAIN) |=> cfg.chain_main ==
      (($past(cfg.chain_main) & ~$past(pwdata[15:8])) |
       ($past(pwdata[7:0]) & $past(pwdata[15:8])));
  endproperty
  a_chain_mask: assert property (p_chain_mask)
    else $error("masked update of chain options wrong");

  property p_flag_w1c;
    wr_to(IDX_ACQ_STAT) |=>
      (acq_flags_r & $past(pwdata[15:8]) & ~$past(meas_evt)) == 8'h00;
  endproperty
  a_flag_w1c: assert property (p_flag_w1c)
    else $error("status flag survived write one");

  // unmapped index is refused with an error in the access cycle
  property p_unmapped_err;
    setup_ph && !rd_hit |=> pready && pslverr;
  endproperty
  a_unmapped_err: assert property (p_unmapped_err)
    else $error("unmapped access not answered with an error");

  // interrupt line follows masked status one cycle late
  property p_irq_level;
    1'b1 |=> irq == |($past(irq_stat_r) & $past(irq_mask_r));
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt line does not follow masked status");

  c_az_finish: cover property (az_finish ##1 done_r);
  c_az_abort: cover property ((state_r == AZ_RUN) ##1
    (state_r == AZ_IDLE));
  c_irq: cover property ($rose(irq));
  c_err: cover property (pready && pslverr);
endmodule : acqc_top

// ===== test/acqc_tb.sv
/*
  testbench: self-checking bench of the acquisition chain control block.
  Assumes acqc_top with its APB slave, a 10 MHz ref_clk and a short
  calibration count set through AZ_TICKS.
*/
`timescale 1ns/1ps
module testbench;
  import acqc_pkg::*;
  // ==========================================================
  // signals
  localparam int unsigned AZT = 8; // shortened calibration count
  logic ref_clk;
  logic rstn;
  logic psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr;
  logic [7:0] meas_evt;
  logic [4:0] chain_status;
  acqc_res_t results;
  logic [3:0][10:0] az_offset_meas;
  acqc_cfg_t cfg;
  logic autozero_run_bit, irq;
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0; // free cycle counter for latency checks
  logic last_err; // response code of the last transfer
  // ==========================================================
  // clock, design
  initial ref_clk = 1'b0;
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;
  acqc_top #(.AZ_TICKS(AZT)) u_acqc_top (.ref_clk(ref_clk), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .meas_evt(meas_evt), .chain_status(chain_status),
    .results(results), .az_offset_meas(az_offset_meas), .cfg(cfg),
    .autozero_run_bit(autozero_run_bit), .irq(irq));
  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer; answer taken at the edge where pready is high
  task automatic apb(input logic wr, input logic [7:0] idx,
      input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h0000_0DEA, 32'h0000_0000);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    apb(1'b1, idx, wd, d);
    // registers launched at the access edge are settled by now
    @(negedge ref_clk);
  endtask : wr
  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    apb(1'b0, idx, 32'h0000_0000, d);
    chk(d, exp);
  endtask : rd_chk
  // ==========================================================
  // scenarios
  task automatic t_reset;
    rd_chk(IDX_VSENSE, 32'h0000_0000);
    rd_chk(IDX_ACQUISITION_CONTROL, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
  endtask : t_reset
  // reserved upper bits of the field registers stay zero
  task automatic t_fields;
    logic [7:0] ix [6] = '{IDX_VSENSE, IDX_TSENSE, IDX_FILTER_COEFFICIENT_INDEX, IDX_GAIN,
      IDX_DEC, IDX_GCB};
    logic [7:0] ex [6] = '{8'hFF, 8'h1F, 8'h0F, 8'hFE, 8'h07, 8'hFF};
    for (int i = 0; i < 6; i++) begin
      wr(ix[i], 32'h0000_00FF);
      rd_chk(ix[i], {24'h0, ex[i]});
    end
    chk({24'h0, cfg.vsense}, 32'h0000_00FF);
    chk({28'h0, cfg.filter_coefficient_index}, 32'h0000_000F);
    chk({29'h0, cfg.dec}, 32'h0000_0007);
    rd_chk(IDX_REFCTL, 32'h0000_0000);
  endtask : t_fields
  // lower byte moves only where the upper byte mask is one
  task automatic t_paired;
    wr(IDX_ACQUISITION_CONTROL, 32'h0000_00FF);
    rd_chk(IDX_ACQUISITION_CONTROL, 32'h0000_0000);
    wr(IDX_ACQUISITION_CONTROL, 32'h0000_FFFF);
    rd_chk(IDX_ACQUISITION_CONTROL, {24'h0, ACQUISITION_CONTROL_WMASK});
    wr(IDX_ACQUISITION_CONTROL, 32'h0000_0100);
    rd_chk(IDX_ACQUISITION_CONTROL, {24'h0, ACQUISITION_CONTROL_WMASK & 8'hFE});
    wr(IDX_CHAIN_ZERO, 32'h0000_8080);
    rd_chk(IDX_CHAIN_ZERO, 32'h0000_0080);
    wr(IDX_CHAIN_MAIN, 32'h0000_0F5A);
    rd_chk(IDX_CHAIN_MAIN, 32'h0000_000A);
    chk({24'h0, cfg.chain_main}, 32'h0000_000A);
  endtask : t_paired
  // sticky measurement flags, live chain bits, masked interrupt
  task automatic t_status;
    chain_status <= 5'h15;
    @(posedge ref_clk);
    meas_evt <= 8'hA5;
    @(posedge ref_clk);
    meas_evt <= 8'h00;
    rd_chk(IDX_ACQ_STAT, 32'h0000_A515);
    wr(IDX_ACQ_STAT, 32'h0000_0000);
    rd_chk(IDX_ACQ_STAT, 32'h0000_A515);
    wr(IDX_ACQ_STAT, 32'h0000_2100);
    rd_chk(IDX_ACQ_STAT, 32'h0000_8415);
    chk({31'h0, irq}, 32'h0000_0000); // masked off
    wr(IDX_IRQ_MASK, 32'h0000_0002);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(IDX_IRQ_STAT, 32'h0000_0002);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h0000_0000);
    rd_chk(IDX_ITEMP, {16'h0, results.itemp});
    rd_chk(IDX_VOLT, {16'h0, results.volt});
    rd_chk(IDX_ETEMP, {16'h0, results.etemp});
    rd_chk(IDX_CURR_UP, {24'h0, results.curr[23:16]});
    rd_chk(IDX_CURR_LO, {16'h0, results.curr[15:0]});
  endtask : t_status
  // unmapped index answers with an error and zero data
  task automatic t_unmapped;
    rd_chk(8'h50, 32'h0000_0000);
    chk({31'h0, last_err}, 32'h0000_0001);
    wr(8'h50, 32'h0000_FFFF);
    chk({31'h0, last_err}, 32'h0000_0001);
    rd_chk(IDX_VSENSE, 32'h0000_00FF);
    chk({31'h0, last_err}, 32'h0000_0000);
  endtask : t_unmapped
  // full calibration sequence as software runs it
  task automatic t_cal;
    logic [31:0] d;
    int t0, el, n, ex;
    ex = AZT * REF_CLK_KHZ / SLOW_CLK_KHZ;
    wr(IDX_COMPENSATION_CONTROL_REGISTER, 32'h0000_0001);
    chk({31'h0, autozero_run_bit}, 32'h0000_0000);
    wr(IDX_COMPENSATION_CONTROL_REGISTER, 32'h0000_0101);
    t0 = cyc;
    chk({31'h0, autozero_run_bit}, 32'h0000_0001);
    rd_chk(IDX_AZ_STAT, 32'h0000_0000);
    n = 0;
    do begin
      apb(1'b0, IDX_AZ_STAT, 32'h0000_0000, d);
      n++;
    end while (d[AZ_DONE_POS] !== 1'b1 && n < 200);
    el = cyc - t0;
    chk({31'h0, el >= ex - 2 && el <= ex + 12}, 32'h0000_0001);
    chk(d, 32'h0000_0001);
    for (int g = 0; g < 4; g++)
      rd_chk({IDX_AZ_CORR_GRP, g[1:0]}, {21'h0, az_offset_meas[g]});
    rd_chk(IDX_IRQ_STAT, 32'h0000_0001);
    wr(IDX_COMPENSATION_CONTROL_REGISTER, 32'h0000_0100);
    chk({31'h0, autozero_run_bit}, 32'h0000_0000);
    wr(IDX_AZ_STAT, 32'h0000_0000);
    rd_chk(IDX_AZ_STAT, 32'h0000_0001);
    wr(IDX_AZ_STAT, 32'h0000_0001);
    rd_chk(IDX_AZ_STAT, 32'h0000_0000);
  endtask : t_cal
  // ==========================================================
  // verdict
  task automatic print_verdict;
    $display("errors=%0d compares=%0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  // watchdog at 20000 cycles, far beyond the few hundred cycles of the run
  initial begin
    #(20_000 * 100);
    num_errors++;
    print_verdict();
  end
  // ==========================================================
  // main sequence
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    meas_evt = 8'h00;
    chain_status = 5'h00;
    results = {16'h1234, 16'h5678, 24'h9ABCDE, 16'h4321};
    az_offset_meas = {11'h7A1, 11'h2B3, 11'h0C5, 11'h4D7};
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    t_reset();
    t_fields();
    t_paired();
    t_status();
    t_unmapped();
    t_cal();
    print_verdict();
  end
endmodule : testbench
